// File: include/pfc_defines.svh
// Register offsets, field positions, command codes and timing counts of the flash host
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PFC_REG_CTRL 8'h00
`define PFC_REG_ADDR 8'h04
`define PFC_REG_WDATA 8'h08
`define PFC_REG_STATUS 8'h0c
`define PFC_CTRL_CMD_LSB 0
`define PFC_STATUS_BUSY_BIT 0
`define PFC_STATUS_DONE_BIT 1
`define PFC_STATUS_LOCK_BIT 2
`define PFC_STATUS_RDATA_LSB 8
`define PFC_ADDR_RESET 19'h00000
`define PFC_WDATA_RESET 8'h00

// ****************************************
// Command codes written to the control register
// ****************************************
`define PFC_CMD_READ 3'h0
`define PFC_CMD_PROGRAM 3'h1
`define PFC_CMD_SECTOR_ERASE 3'h2
`define PFC_CMD_CHIP_ERASE 3'h3
`define PFC_CMD_LOCKOUT 3'h4
`define PFC_CMD_ID_ENTRY 3'h5
`define PFC_CMD_ID_EXIT 3'h6
`define PFC_CMD_ID_EXIT_SHORT 3'h7

// ****************************************
// Flash command addresses and data
// ****************************************
`define PFC_UNLOCK_ADDR1 19'h00555
`define PFC_UNLOCK_ADDR2 19'h00aaa
`define PFC_UNLOCK_DATA1 8'haa
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_OP_PROGRAM 8'ha0
`define PFC_OP_ERASE_SETUP 8'h80
`define PFC_OP_CHIP_ERASE 8'h10
`define PFC_OP_SECTOR_ERASE 8'h30
`define PFC_OP_LOCKOUT 8'h40
`define PFC_OP_ID_ENTRY 8'h90
`define PFC_OP_ID_EXIT 8'hf0
`define PFC_ID_LOCK_ADDR 19'h00002
`define PFC_TOGGLE_BIT 6

// ****************************************
// Timing
// ****************************************
`define PFC_CLK_MHZ 20
`define PFC_WE_PULSE_NS 100
`define PFC_READ_ACCESS_NS 70
`define PFC_SYNC_STAGES 2
// Least times round up to whole cycles
`define PFC_WE_PULSE_CYC ((`PFC_WE_PULSE_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_READ_CYC (((`PFC_READ_ACCESS_NS * `PFC_CLK_MHZ + 999) / 1000) + `PFC_SYNC_STAGES)

`endif

// File: include/pfc_pkg.sv
// Types shared by the flash host controller
package pfc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_RD_SETUP,
    ST_RD_WAIT,
    ST_RD_GAP,
    ST_DONE
  } pfc_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dout;
    logic doe;
  } pfc_pins_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
  } pfc_step_t;

endpackage

// File: rtl/pfc_host.sv
// Host controller that runs command sequences on a byte-wide parallel flash
`timescale 1ns/1ps
`include "pfc_defines.svh"

// Notes on behaviour
// - Byte program: AA, 55, A0, then data
// - Lockout: six cycles ending 555 with 40
// - ID entry: AA, 55, then 90
// - ID exit: three cycles or single F0
// - Sector erase ends with sector address, 30
module pfc_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Flash pins
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [18:0] flash_addr_o,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [7:0] flash_dq_i
);

  localparam logic [3:0] WE_CYC = 4'(`PFC_WE_PULSE_CYC);
  localparam logic [3:0] RD_CYC = 4'(`PFC_READ_CYC);
  // ****************************************
  // Command sequence tables
  // ****************************************
  function automatic logic [2:0] seq_len(input logic [2:0] cmd);
    case (cmd)
      `PFC_CMD_PROGRAM: seq_len = 3'd4;
      `PFC_CMD_SECTOR_ERASE, `PFC_CMD_CHIP_ERASE, `PFC_CMD_LOCKOUT: seq_len = 3'd6;
      `PFC_CMD_ID_ENTRY, `PFC_CMD_ID_EXIT: seq_len = 3'd3;
      `PFC_CMD_ID_EXIT_SHORT: seq_len = 3'd1;
      default: seq_len = 3'd0;
    endcase
  endfunction
  function automatic logic needs_poll(input logic [2:0] cmd);
    case (cmd)
      `PFC_CMD_PROGRAM, `PFC_CMD_SECTOR_ERASE, `PFC_CMD_CHIP_ERASE, `PFC_CMD_LOCKOUT:
        needs_poll = 1'b1;
      default: needs_poll = 1'b0;
    endcase
  endfunction
  // Every sequence except the single-cycle ID exit shares the two unlock cycles; only the low bits matter to the device
  function automatic pfc_pkg::pfc_step_t seq_step(input logic [2:0] cmd,
                                                 input logic [2:0] idx,
                                                 input logic [18:0] ta,
                                                 input logic [7:0] td);
    pfc_pkg::pfc_step_t s;
    s.addr = `PFC_UNLOCK_ADDR1;
    s.data = `PFC_UNLOCK_DATA1;
    case (idx)
      3'd0: begin
        if (cmd == `PFC_CMD_ID_EXIT_SHORT) begin
          s.addr = ta;
          s.data = `PFC_OP_ID_EXIT;
        end
      end
      3'd1, 3'd4: begin
        s.addr = `PFC_UNLOCK_ADDR2;
        s.data = `PFC_UNLOCK_DATA2;
      end
      3'd2: begin
        case (cmd)
          `PFC_CMD_PROGRAM: s.data = `PFC_OP_PROGRAM;
          `PFC_CMD_ID_ENTRY: s.data = `PFC_OP_ID_ENTRY;
          `PFC_CMD_ID_EXIT: s.data = `PFC_OP_ID_EXIT;
          default: s.data = `PFC_OP_ERASE_SETUP;
        endcase
      end
      3'd3: begin
        if (cmd == `PFC_CMD_PROGRAM) begin
          s.addr = ta;
          s.data = td;
        end
      end
      3'd5: begin
        case (cmd)
          `PFC_CMD_SECTOR_ERASE: begin
            s.addr = ta;
            s.data = `PFC_OP_SECTOR_ERASE;
          end
          `PFC_CMD_CHIP_ERASE: s.data = `PFC_OP_CHIP_ERASE;
          default: s.data = `PFC_OP_LOCKOUT;
        endcase
      end
      default: s.data = `PFC_UNLOCK_DATA1;
    endcase
    seq_step = s;
  endfunction
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge_sel[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  pfc_pkg::pfc_state_t state_ff;
  pfc_pkg::pfc_pins_t pins_ff;
  pfc_pkg::pfc_step_t cur_step;
  logic [2:0] cmd_ff;
  logic [2:0] step_ff;
  logic [3:0] cnt_ff;
  logic [18:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic busy_ff;
  logic done_ff;
  logic polling_ff;
  logic have_prev_ff;
  logic prev_toggle_ff;
  logic [7:0] dq_meta_ff;
  logic [7:0] dq_sync_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic wb_hit;
  logic wb_wr;
  logic start;
  logic done_set;
  logic done_clr;
  logic [31:0] status_word;
  logic [31:0] addr_word;
  logic [31:0] wdata_word;
  logic [31:0] addr_merge;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  assign wb_wr = wb_hit && wb_we_i;
  // Commands written while busy are dropped; software must wait for busy low
  assign start = wb_wr && (wb_adr_i == `PFC_REG_CTRL) && wb_sel_i[0] && !busy_ff;
  assign done_set = (state_ff == pfc_pkg::ST_DONE);
  assign done_clr = wb_wr && (wb_adr_i == `PFC_REG_STATUS) && wb_sel_i[0]
                    && wb_dat_i[`PFC_STATUS_DONE_BIT];
  assign cur_step = seq_step(cmd_ff, step_ff, addr_ff, wdata_ff);
  assign addr_word = {13'h0000, addr_ff};
  assign wdata_word = {24'h000000, wdata_ff};
  assign status_word = {16'h0000, rdata_ff, 5'h00, rdata_ff[0], done_ff, busy_ff};
  assign addr_merge = merge_sel(addr_word, wb_dat_i, wb_sel_i);

  // ****************************************
  // Wishbone slave
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h00000000;
    end else begin
      wb_ack_ff <= wb_hit;
      case (wb_adr_i)
        `PFC_REG_CTRL: wb_dat_ff <= {29'h00000000, cmd_ff};
        `PFC_REG_ADDR: wb_dat_ff <= addr_word;
        `PFC_REG_WDATA: wb_dat_ff <= wdata_word;
        `PFC_REG_STATUS: wb_dat_ff <= status_word;
        default: wb_dat_ff <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= `PFC_ADDR_RESET;
      wdata_ff <= `PFC_WDATA_RESET;
    end else if (wb_wr && !busy_ff) begin
      if (wb_adr_i == `PFC_REG_ADDR) begin
        addr_ff <= addr_merge[18:0];
      end
      if (wb_adr_i == `PFC_REG_WDATA && wb_sel_i[0]) begin
        wdata_ff <= wb_dat_i[7:0];
      end
    end
  end
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else if (done_set) begin
      done_ff <= 1'b1;
    end else if (done_clr) begin
      done_ff <= 1'b0;
    end
  end

  // ****************************************
  // Data pin synchroniser
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_meta_ff <= 8'h00;
      dq_sync_ff <= 8'h00;
    end else begin
      dq_meta_ff <= flash_dq_i;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // ****************************************
  // Flash sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= pfc_pkg::ST_IDLE;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      cmd_ff <= `PFC_CMD_READ;
      step_ff <= 3'd0;
      cnt_ff <= 4'h0;
      rdata_ff <= 8'h00;
      busy_ff <= 1'b0;
      polling_ff <= 1'b0;
      have_prev_ff <= 1'b0;
      prev_toggle_ff <= 1'b0;
    end else begin
      case (state_ff)
        pfc_pkg::ST_IDLE: begin
          if (start) begin
            cmd_ff <= wb_dat_i[`PFC_CTRL_CMD_LSB +: 3];
            busy_ff <= 1'b1;
            step_ff <= 3'd0;
            polling_ff <= 1'b0;
            have_prev_ff <= 1'b0;
            if (wb_dat_i[`PFC_CTRL_CMD_LSB +: 3] == `PFC_CMD_READ) begin
              state_ff <= pfc_pkg::ST_RD_SETUP;
            end else begin
              state_ff <= pfc_pkg::ST_WR_SETUP;
            end
          end
        end
        pfc_pkg::ST_WR_SETUP: begin
          // OE high and address stable before WE falls; CE falls in this same cycle
          pins_ff.oe_n <= 1'b1;
          pins_ff.addr <= cur_step.addr;
          pins_ff.dout <= cur_step.data;
          pins_ff.doe <= 1'b1;
          pins_ff.ce_n <= 1'b0;
          state_ff <= pfc_pkg::ST_WR_PULSE;
          cnt_ff <= WE_CYC;
        end
        pfc_pkg::ST_WR_PULSE: begin
          // Strobe held low well past the glitch filter
          pins_ff.we_n <= 1'b0;
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            state_ff <= pfc_pkg::ST_WR_HOLD;
          end
        end
        pfc_pkg::ST_WR_HOLD: begin
          // WE rises first, so data is latched while still driven
          if (!pins_ff.we_n) begin
            pins_ff.we_n <= 1'b1;
          end else begin
            pins_ff.ce_n <= 1'b1;
            pins_ff.doe <= 1'b0;
            step_ff <= step_ff + 3'd1;
            if (step_ff + 3'd1 != seq_len(cmd_ff)) begin
              state_ff <= pfc_pkg::ST_WR_SETUP;
            end else if (needs_poll(cmd_ff)) begin
              polling_ff <= 1'b1;
              state_ff <= pfc_pkg::ST_RD_SETUP;
            end else begin
              state_ff <= pfc_pkg::ST_DONE;
            end
          end
        end
        pfc_pkg::ST_RD_SETUP: begin
          // Polls read the last loaded address
          pins_ff.addr <= addr_ff;
          pins_ff.doe <= 1'b0;
          pins_ff.ce_n <= 1'b0;
          pins_ff.oe_n <= 1'b0;
          cnt_ff <= RD_CYC;
          state_ff <= pfc_pkg::ST_RD_WAIT;
        end
        pfc_pkg::ST_RD_WAIT: begin
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            rdata_ff <= dq_sync_ff;
            pins_ff.ce_n <= 1'b1;
            pins_ff.oe_n <= 1'b1;
            state_ff <= pfc_pkg::ST_RD_GAP;
          end
        end
        pfc_pkg::ST_RD_GAP: begin
          // Busy while the toggle bit differs between successive reads
          if (!polling_ff) begin
            state_ff <= pfc_pkg::ST_DONE;
          end else if (have_prev_ff && prev_toggle_ff == rdata_ff[`PFC_TOGGLE_BIT]) begin
            state_ff <= pfc_pkg::ST_DONE;
          end else begin
            have_prev_ff <= 1'b1;
            prev_toggle_ff <= rdata_ff[`PFC_TOGGLE_BIT];
            state_ff <= pfc_pkg::ST_RD_SETUP;
          end
        end
        pfc_pkg::ST_DONE: begin
          busy_ff <= 1'b0;
          polling_ff <= 1'b0;
          state_ff <= pfc_pkg::ST_IDLE;
        end
        default: state_ff <= pfc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign {flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_addr_o, flash_dq_o,
          flash_dq_oe_o} = pins_ff;

endmodule

// File: dv/pfc_host_asserts.sv
// Checker for the flash host pin timing and bus handshake
`timescale 1ns/1ps
module pfc_host_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Flash pins
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic [18:0] flash_addr_o,
  input wire logic flash_dq_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_we_inhibit: assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o)
    else $error("strobe while inhibited");
  chk_we_width: assert property ($fell(flash_we_n_o) |=> !flash_we_n_o ##1 flash_we_n_o)
    else $error("strobe width");
  chk_addr_hold: assert property (!flash_we_n_o |-> $stable(flash_addr_o))
    else $error("address moved");
  chk_data_hold: assert property ($rose(flash_we_n_o) |-> flash_dq_oe_o && !flash_ce_n_o)
    else $error("data dropped early");
  chk_ce_after_we: assert property ($rose(flash_ce_n_o) |-> $past(flash_we_n_o))
    else $error("select ended first");
  chk_no_contend: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("bus contention");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o && $past(wb_stb_i, 2))
    else $error("ack too long");
endmodule
bind pfc_host pfc_host_asserts u_pfc_host_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o), .flash_addr_o(flash_addr_o),
  .flash_dq_oe_o(flash_dq_oe_o));

// File: dv/pfc_flash_model.sv
// Behavioural model of the byte-wide flash device
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hc3 // Arbitrary value
) (
  // Host pins
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [0:19'h7ffff];
  logic [7:0] pd = 8'hff;
  logic [7:0] dv;
  logic [18:0] la;
  logic busy = 1'b0;
  logic tog = 1'b0;
  logic lock = 1'b0;
  logic idm = 1'b0;
  int st = 0;
  // Far future start time, so power-up unknowns never count as a write
  realtime tf = 1.0e12;
  event go;
  wire wr = !ce_n_i && !we_n_i && oe_n_i;
  wire sel = !ce_n_i && !oe_n_i;
  initial foreach (mem[i]) mem[i] = 8'hff;
  task automatic start(input logic [7:0] v);
    pd = v;
    busy = 1'b1;
    -> go;
  endtask
  task automatic wipe(input logic [18:0] lo, input logic [18:0] hi);
    for (int k = lo; k <= hi; k++)
      if (!(lock && k < 19'h4000)) mem[k] = 8'hff;
    start(8'hff);
  endtask
  task automatic step(input logic [18:0] a, input logic [7:0] v);
    logic [10:0] c;
    logic [18:0] m;
    c = a[10:0];
    m = a < 19'h4000 ? 19'h3fff : a < 19'h8000 ? 19'h1fff : a < 19'h10000 ? 19'h7fff : 19'hffff;
    if (idm && st == 0 && v == 8'hf0) idm = 1'b0;
    else case (st)
      0, 4: st = (c == 11'h555 && v == 8'haa) ? st + 1 : 0;
      1, 5: st = (c == 11'h2aa && v == 8'h55) ? st + 1 : 0;
      2: begin
        st = c != 11'h555 ? 0 : v == 8'ha0 ? 3 : v == 8'h80 ? 4 : 0;
        if (c == 11'h555 && v == 8'h90) idm = 1'b1;
        if (c == 11'h555 && v == 8'hf0) idm = 1'b0;
      end
      3: begin
        st = 0;
        if (!(lock && a < 19'h4000)) mem[a] = mem[a] & v;
        start(v);
      end
      default: begin
        st = 0;
        if (c == 11'h555 && v == 8'h40) lock = 1'b1;
        else if (c == 11'h555 && v == 8'h10) wipe(19'h0, 19'h7ffff);
        else if (v == 8'h30) wipe(a & ~m, a | m);
      end
    endcase
  endtask
  always @(posedge wr) begin
    la = addr_i;
    tf = $realtime;
  end
  // Writes during an operation are dropped
  always @(negedge wr) if (!busy && $realtime - tf >= 15.0) step(la, dq_i);
  always @(go) begin
    #(BUSY_NS);
    busy = 1'b0;
  end
  always @(negedge sel) if (busy) tog = ~tog;
  always @* begin
    if (busy) dv = {~pd[7], tog, 6'h00};
    else if (idm) dv = addr_i == 19'h2 ? {7'h0, lock} : addr_i[0] ? PART_ID : MAKER_ID;
    else dv = mem[addr_i];
    // Released bus shows no stale byte
    dq_o = sel ? dv : ~dv;
  end
endmodule

// File: dv/test_pfc_host.sv
// Self-checking bench for the flash host driving the flash model
`timescale 1ns/1ps
`include "pfc_defines.svh"
module test_pfc_host;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] PART = 8'hc3; // Arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr, st, res;
  logic [31:0] seed = 32'h8bf5;
  logic ack, ce_n, oe_n, we_n, dq_oe;
  logic [18:0] fa;
  logic [7:0] fd, fq;
  int num_errors = 0;
  int compares = 0;
  wire logic [7:0] dq = dq_oe ? fd : fq;
  always #25 clk_i = ~clk_i;
  pfc_host u_pfc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .flash_addr_o(fa), .flash_dq_o(fd), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq));
  pfc_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_pfc_flash_model (.ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fa), .dq_i(dq), .dq_o(fq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] id_val(input int i, input logic lk);
    return i == 2 ? {7'h0, lk} : i == 1 ? PART : MAKER;
  endfunction
  task automatic stop_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    st = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic run(input logic [2:0] c, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb(1'b1, `PFC_REG_ADDR, {13'h0, a});
    wb(1'b1, `PFC_REG_WDATA, {24'h0, d});
    wb(1'b1, `PFC_REG_CTRL, {29'h0, c});
    do begin
      wb(1'b0, `PFC_REG_STATUS, 32'h0);
      n++;
    end while (st[0] !== 1'b0 && n < 300);
    res = st;
    check({7'h0, res[0]}, 8'h00);
    check({7'h0, res[1]}, 8'h01);
    wb(1'b1, `PFC_REG_STATUS, 32'h2);
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] exp);
    run(`PFC_CMD_READ, a, 8'h00);
    check(res[15:8], exp);
  endtask
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
  initial begin
    logic [18:0] a;
    logic [7:0] d, e;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `PFC_REG_STATUS, 32'h0);
    check(st[7:0], 8'h00);
    wb(1'b0, 8'h40, 32'h0);
    check(st[7:0], 8'h00);
    for (int i = 0; i < 5; i++) begin
      a = 19'h08000 + 19'(rnd() % 32'h78000);
      d = 8'(rnd());
      e = 8'(rnd());
      run(`PFC_CMD_PROGRAM, a, d);
      run(`PFC_CMD_PROGRAM, a, e);
      rd(a, d & e);
    end
    run(`PFC_CMD_PROGRAM, 19'h00100, 8'h3c);
    run(`PFC_CMD_ID_ENTRY, 19'h0, 8'h00);
    for (int i = 0; i < 3; i++) rd(19'(i), id_val(i, 1'b0));
    run(`PFC_CMD_ID_EXIT_SHORT, 19'h12345, 8'h00);
    rd(a, d & e);
    run(`PFC_CMD_LOCKOUT, 19'h0, 8'h00);
    run(`PFC_CMD_ID_ENTRY, 19'h0, 8'h00);
    rd(19'h2, id_val(2, 1'b1));
    check({7'h0, res[2]}, 8'h01);
    run(`PFC_CMD_ID_EXIT, 19'h0, 8'h00);
    run(`PFC_CMD_PROGRAM, 19'h00100, 8'h00);
    run(`PFC_CMD_SECTOR_ERASE, 19'h00000, 8'h00);
    rd(19'h00100, 8'h3c);
    run(`PFC_CMD_PROGRAM, 19'h04100, 8'h5a);
    run(`PFC_CMD_PROGRAM, 19'h06000, 8'ha5);
    rd(19'h04100, 8'h5a);
    run(`PFC_CMD_SECTOR_ERASE, 19'h05fff, 8'h00);
    rd(19'h04100, 8'hff);
    rd(19'h06000, 8'ha5);
    run(`PFC_CMD_CHIP_ERASE, 19'h0, 8'h00);
    rd(19'h06000, 8'hff);
    rd(19'h00100, 8'h3c);
    stop_test();
  end
endmodule
